//--- core/qpt_core.sv
`timescale 1ns/100ps
module qpt_core
  import qpt_pkg::*;
#(
  parameter int WRITE_CYCLES = qpt_pkg::NV_WRITE_CYCLES,
  parameter logic [3:0] DEVICE_TYPE = qpt_pkg::DEVICE_TYPE_DEFAULT
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [3:0] address_select_inputs,
  output logic [qpt_pkg::POTS*qpt_pkg::TAPS-1:0] tap_switch_on,
  output logic [qpt_pkg::POTS-1:0] chain_enable_flag,
  output logic [qpt_pkg::POTS-1:0] wiper_off_flag,
  output logic nv_write_busy
);
  import qpt_pkg::*;

  localparam int BUSY_W = $clog2(WRITE_CYCLES + 1);
  localparam int SET_W = $clog2(WIPER_SETTLE_CYCLES + 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    qpt_state_t state;
    qpt_state_t ack_next;
    logic scl_q;
    logic sda_q;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic ack_on;
    logic oe_n;
    logic [3:0] opcode;
    logic [1:0] pot;
    logic [3:0] cmd_addr;
    logic [POTS-1:0][DATA_W-1:0] wiper;
    logic [POTS-1:0][DATA_W-1:0] shown;
    logic [SET_W-1:0] settle_cnt;
    logic [2:0] ld_left;
    logic [1:0] ld_idx;
    logic [1:0] ld_reg;
    logic ld_wr;
    logic [1:0] ld_wr_idx;
    logic nv_pend;
    logic nv_all;
    logic [3:0] nv_addr;
    logic [7:0] nv_data;
    logic busy;
    logic [BUSY_W-1:0] busy_cnt;
    logic [2:0] wr_left;
    logic [1:0] wr_idx;
  } qpt_core_t;

  qpt_core_t r;
  qpt_core_t n;

  logic scl_s;
  logic sda_s;
  logic [3:0] addr_s;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic rx_state;
  logic got_byte;
  logic [7:0] byte_in;
  logic [5:0] pos;
  logic mem_we;
  logic [3:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [3:0] mem_raddr;
  logic [7:0] mem_q;

  // ----------------------------------------------------------------
  // pin sampling and storage
  // ----------------------------------------------------------------
  qpt_sync2 #(
    .WIDTH(6),
    .RST_VAL(6'h3F)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d({scl, sda_in, address_select_inputs}),
    .q({scl_s, sda_s, addr_s})
  );

  qpt_nv_store #(
    .DEPTH(POTS * REGS),
    .WIDTH(DATA_W)
  ) u_store (
    .clk(clk),
    .wr_en(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata),
    .rd_addr(mem_raddr),
    .rd_data(mem_q)
  );

  // ----------------------------------------------------------------
  // line events, seen from the synchronised copies
  // ----------------------------------------------------------------
  assign scl_rise = scl_s & ~r.scl_q;
  assign scl_fall = ~scl_s & r.scl_q;
  assign start_seen = scl_s & r.scl_q & r.sda_q & ~sda_s;
  assign stop_seen = scl_s & r.scl_q & ~r.sda_q & sda_s;
  assign rx_state = (r.state == S_ADDR) | (r.state == S_INSTR) |
    (r.state == S_DATA);
  assign got_byte = rx_state & scl_rise & (r.bit_cnt == LAST_BIT);
  assign byte_in = {r.shift[6:0], sda_s}; // msb first
  assign pos = r.wiper[r.pot][POS_W-1:0];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.scl_q = scl_s;
    n.sda_q = sda_s;
    mem_we = 1'b0;
    mem_waddr = r.nv_addr;
    mem_wdata = r.nv_data;
    mem_raddr = r.cmd_addr;

    // recall: read one setting per cycle, land it a cycle later
    if (r.ld_left != 3'h0) begin
      mem_raddr = {r.ld_idx, r.ld_reg};
      n.ld_wr = 1'b1;
      n.ld_wr_idx = r.ld_idx;
      n.ld_idx = r.ld_idx + 2'h1;
      n.ld_left = r.ld_left - 3'h1;
    end else begin
      n.ld_wr = 1'b0;
    end
    if (r.ld_wr) begin
      n.wiper[r.ld_wr_idx] = mem_q;
    end

    // nonvolatile write cycle; store is written at its first cycles
    if (r.busy) begin
      if (r.wr_left != 3'h0) begin
        mem_we = 1'b1;
        if (r.nv_all) begin
          mem_waddr = {r.wr_idx, r.nv_addr[1:0]};
          mem_wdata = r.wiper[r.wr_idx];
        end
        n.wr_idx = r.wr_idx + 2'h1;
        n.wr_left = r.wr_left - 3'h1;
      end
      if (r.busy_cnt == '0) begin
        n.busy = 1'b0;
      end else begin
        n.busy_cnt = r.busy_cnt - BUSY_W'(1);
      end
    end

    // receive shift register
    if (rx_state && scl_rise) begin
      n.shift = byte_in;
      n.bit_cnt = r.bit_cnt + 4'h1;
    end

    // link sequence
    unique case (r.state)
      S_IDLE: begin
        n.oe_n = 1'b1;
      end
      S_ADDR: begin
        if (got_byte) begin
          if (byte_in[7:4] == DEVICE_TYPE &&
              byte_in[3:0] == addr_s) begin
            n.state = S_ACK;
            n.ack_next = S_INSTR;
          end else begin
            n.state = S_SKIP;
          end
        end
      end
      S_INSTR: begin
        if (got_byte) begin
          n.opcode = byte_in[7:OP_LSB];
          n.pot = byte_in[POT_LSB+1:POT_LSB];
          n.cmd_addr = byte_in[3:0];
          n.state = S_ACK;
          n.ack_next = S_SKIP;
          unique case (byte_in[7:OP_LSB])
            OP_RD_WPR, OP_RD_SSR: n.ack_next = S_SEND;
            OP_WR_WPR, OP_WR_SSR: n.ack_next = S_DATA;
            OP_SSR_TO_WPR: begin
              n.ld_idx = byte_in[POT_LSB+1:POT_LSB];
              n.ld_reg = byte_in[REG_LSB+1:REG_LSB];
              n.ld_left = ONE_ENTRY;
            end
            OP_ALL_SSR_TO_WPR: begin
              n.ld_idx = 2'h0;
              n.ld_reg = byte_in[REG_LSB+1:REG_LSB];
              n.ld_left = ALL_ENTRIES;
            end
            OP_WPR_TO_SSR: begin
              n.nv_pend = 1'b1;
              n.nv_all = 1'b0;
              n.nv_addr = byte_in[3:0];
              n.nv_data = r.wiper[byte_in[POT_LSB+1:POT_LSB]];
            end
            OP_ALL_WPR_TO_SSR: begin
              n.nv_pend = 1'b1;
              n.nv_all = 1'b1;
              n.nv_addr = byte_in[3:0];
            end
            OP_STEP: n.ack_next = S_STEP;
            default: n.state = S_SKIP;
          endcase
        end
      end
      S_DATA: begin
        if (got_byte) begin
          n.state = S_ACK;
          n.ack_next = S_SKIP;
          if (r.opcode == OP_WR_WPR) begin
            n.wiper[r.pot] = byte_in;
          end else begin
            n.nv_pend = 1'b1;
            n.nv_all = 1'b0;
            n.nv_addr = r.cmd_addr;
            n.nv_data = byte_in;
          end
        end
      end
      S_ACK: begin
        // pull low on the fall after bit 8, free it after clock 9
        if (scl_fall) begin
          if (!r.ack_on) begin
            n.ack_on = 1'b1;
            n.oe_n = 1'b0;
          end else begin
            n.ack_on = 1'b0;
            n.oe_n = 1'b1;
            n.state = r.ack_next;
            n.bit_cnt = 4'h0;
            if (r.ack_next == S_SEND) begin
              n.tx = (r.opcode == OP_RD_SSR) ? mem_q : r.wiper[r.pot];
              n.oe_n = n.tx[7];
              n.tx = {n.tx[6:0], 1'b0};
              n.bit_cnt = 4'h1;
            end
          end
        end
      end
      S_SEND: begin
        if (scl_fall) begin
          if (r.bit_cnt == LAST_BIT + 4'h1) begin
            n.oe_n = 1'b1;
            n.state = S_MACK;
          end else begin
            n.oe_n = r.tx[7];
            n.tx = {r.tx[6:0], 1'b0};
            n.bit_cnt = r.bit_cnt + 4'h1;
          end
        end
      end
      S_MACK: begin
        // the master's own answer is not needed: one byte per read
        if (scl_fall) begin
          n.state = S_SKIP;
        end
      end
      S_STEP: begin
        if (scl_rise) begin
          if (sda_s && pos != POS_MAX) begin
            n.wiper[r.pot][POS_W-1:0] = pos + 6'h01;
          end else if (!sda_s && pos != POS_MIN) begin
            n.wiper[r.pot][POS_W-1:0] = pos - 6'h01;
          end
        end
      end
      S_SKIP: begin
        n.oe_n = 1'b1;
      end
      default: begin
        n.state = S_IDLE;
        n.oe_n = 1'b1;
      end
    endcase

    // start and stop override the sequence; a write cycle mutes both
    if (start_seen && !r.busy) begin
      n.state = S_ADDR;
      n.bit_cnt = 4'h0;
      n.ack_on = 1'b0;
      n.oe_n = 1'b1;
      n.nv_pend = 1'b0;
    end else if (stop_seen) begin
      n.state = S_IDLE;
      n.ack_on = 1'b0;
      n.oe_n = 1'b1;
      if (r.nv_pend && !r.busy) begin
        n.nv_pend = 1'b0;
        n.busy = 1'b1;
        n.busy_cnt = BUSY_W'(WRITE_CYCLES - 1);
        n.wr_idx = 2'h0;
        n.wr_left = r.nv_all ? ALL_ENTRIES : ONE_ENTRY;
      end
    end
    if (r.busy) begin
      n.state = S_IDLE;
      n.oe_n = 1'b1;
    end

    // taps follow the wiper register after a settle delay
    if (r.wiper != r.shown) begin
      if (r.settle_cnt == SET_W'(WIPER_SETTLE_CYCLES - 1)) begin
        n.shown = r.wiper;
        n.settle_cnt = '0;
      end else begin
        n.settle_cnt = r.settle_cnt + SET_W'(1);
      end
    end else begin
      n.settle_cnt = '0;
    end
  end

  // ----------------------------------------------------------------
  // register; reset starts the power-up recall from setting 0
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      r <= '0;
      r.state <= S_IDLE;
      r.ack_next <= S_IDLE;
      r.scl_q <= 1'b1;
      r.sda_q <= 1'b1;
      r.oe_n <= 1'b1;
      r.ld_left <= ALL_ENTRIES;
      r.ld_reg <= RECALL_REG;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs; open drain, so only the enable moves
  // ----------------------------------------------------------------
  assign sda_out = 1'b0;
  assign sda_oe_n = r.oe_n;
  assign nv_write_busy = r.busy;

  // one-hot tap decode per pot: always exactly one switch on
  for (genvar g = 0; g < POTS; g++) begin : g_tap
    assign tap_switch_on[g*TAPS +: TAPS] =
      {{(TAPS-1){1'b0}}, 1'b1} << r.shown[g][POS_W-1:0];
    assign chain_enable_flag[g] = r.shown[g][CHAIN_BIT];
    assign wiper_off_flag[g] = r.shown[g][WOFF_BIT];
  end

endmodule

//--- core/qpt_nv_store.sv
`timescale 1ns/100ps
module qpt_nv_store #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 8,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // --------------------------------------------------------------
  // storage has no reset: it models memory that survives power-down
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr]; // one cycle read latency
  end

endmodule

//--- core/qpt_pkg.sv
package qpt_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  // typical nonvolatile write time, well inside the 10 ms worst case
  localparam int NV_WRITE_TIME_NS = 5000000;
  localparam int NV_WRITE_CYCLES = NV_WRITE_TIME_NS / CLK_PERIOD_NS;
  // wiper settle delay; least time, so round up
  localparam int WIPER_SETTLE_NS = 1000;
  localparam int WIPER_SETTLE_CYCLES =
    (WIPER_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // geometry and field layout
  // ----------------------------------------------------------------
  localparam int POTS = 4;
  localparam int REGS = 4;
  localparam int TAPS = 64;
  localparam int DATA_W = 8;
  localparam int POS_W = 6;
  localparam int CHAIN_BIT = 7;
  localparam int WOFF_BIT = 6;
  localparam int OP_LSB = 4;
  localparam int POT_LSB = 2;
  localparam int REG_LSB = 0;
  localparam logic [5:0] POS_MAX = 6'h3F;
  localparam logic [5:0] POS_MIN = 6'h00;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [2:0] ONE_ENTRY = 3'h1;
  localparam logic [2:0] ALL_ENTRIES = 3'h4;
  localparam logic [1:0] RECALL_REG = 2'h0;
  // device type code; value is arbitrary
  localparam logic [3:0] DEVICE_TYPE_DEFAULT = 4'h9;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_RD_WPR = 4'h9;
  localparam logic [3:0] OP_WR_WPR = 4'hA;
  localparam logic [3:0] OP_RD_SSR = 4'hB;
  localparam logic [3:0] OP_WR_SSR = 4'hC;
  localparam logic [3:0] OP_SSR_TO_WPR = 4'hD;
  localparam logic [3:0] OP_WPR_TO_SSR = 4'hE;
  localparam logic [3:0] OP_ALL_SSR_TO_WPR = 4'h1;
  localparam logic [3:0] OP_ALL_WPR_TO_SSR = 4'h8;
  localparam logic [3:0] OP_STEP = 4'h2;

  // ----------------------------------------------------------------
  // link states
  // ----------------------------------------------------------------
  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_ADDR = 9'h002,
    S_INSTR = 9'h004,
    S_DATA = 9'h008,
    S_ACK = 9'h010,
    S_SEND = 9'h020,
    S_MACK = 9'h040,
    S_STEP = 9'h080,
    S_SKIP = 9'h100
  } qpt_state_t;

endpackage

//--- core/qpt_sync2.sv
`timescale 1ns/100ps
module qpt_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // --------------------------------------------------------------
  // two stages; only the second stage is read outside
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

//--- verif/qpt_core_chk.sv
`timescale 1ns/100ps
module qpt_core_chk
  import qpt_pkg::*;
#(
  parameter int WRITE_CYCLES = qpt_pkg::NV_WRITE_CYCLES,
  parameter logic [3:0] DEVICE_TYPE = qpt_pkg::DEVICE_TYPE_DEFAULT
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic [3:0] address_select_inputs,
  input wire logic [qpt_pkg::POTS*qpt_pkg::TAPS-1:0] tap_switch_on,
  input wire logic [qpt_pkg::POTS-1:0] chain_enable_flag,
  input wire logic [qpt_pkg::POTS-1:0] wiper_off_flag,
  input wire logic nv_write_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------
  // helpers
  // ----------
  // settings survive reset, so the write tally does too; taps are only
  // trusted once all sixteen are written and a later reset recalled them
  logic [15:0] busy_len = '0;
  logic [4:0] nv_done = '0;
  always_ff @(posedge clk) begin
    busy_len <= nv_write_busy ? busy_len + 16'h1 : 16'h0;
    if ($fell(nv_write_busy) && nv_done < 5'h10) begin
      nv_done <= nv_done + 5'h1;
    end else if (!resetn && nv_done == 5'h10) begin
      nv_done <= 5'h11;
    end
  end
  a_drive_clk_low: assert property ($changed(sda_oe_n) |-> !scl)
    else $error("data drive changed with clock high");
  a_pull_holds: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*6])
    else $error("data pull shorter than a bit");
  a_busy_silent: assert property (nv_write_busy |-> sda_oe_n)
    else $error("acknowledge during write cycle");
  a_busy_length: assert property
    ($fell(nv_write_busy) |-> busy_len == WRITE_CYCLES)
    else $error("write cycle length wrong");
  a_busy_at_stop: assert property
    ($rose(nv_write_busy) |-> scl && sda_in && $past(scl, 2))
    else $error("write cycle began without a stop");
  a_taps_held: assert property
    (nv_write_busy && $past(nv_write_busy) |-> $stable(tap_switch_on))
    else $error("wiper moved during write cycle");
  a_reset_quiet: assert property (disable iff (1'b0)
    !resetn |=> sda_oe_n && !nv_write_busy && tap_switch_on[0]
      && tap_switch_on[TAPS] && tap_switch_on[2*TAPS]
      && tap_switch_on[3*TAPS])
    else $error("outputs not idle in reset");
  for (genvar g = 0; g < POTS; g++) begin : g_pot
    a_tap_onehot: assert property
      (nv_done == 5'h11 |-> $onehot(tap_switch_on[g*TAPS +: TAPS]))
      else $error("tap switches not one-hot");
  end
endmodule
bind qpt_core qpt_core_chk #(
  .WRITE_CYCLES(WRITE_CYCLES),
  .DEVICE_TYPE(DEVICE_TYPE)
) u_chk (
  .clk(clk), .resetn(resetn), .scl(scl), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .address_select_inputs(address_select_inputs),
  .tap_switch_on(tap_switch_on), .chain_enable_flag(chain_enable_flag),
  .wiper_off_flag(wiper_off_flag), .nv_write_busy(nv_write_busy)
);

//--- verif/qpt_master.sv
`timescale 1ns/100ps
module qpt_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low,
  output logic res_tgl,
  output logic [7:0] res_val
);
  // ----------
  // bus master
  // ----------
  // clock rests high between frames; low phase is the longer one so the
  // slave's synchroniser lag still lands its drive inside it
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    res_tgl = 1'b0;
    res_val = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic report(input logic [7:0] v);
    res_val = v;
    res_tgl = ~res_tgl;
  endtask
  task automatic bit_io(input logic b, output logic s);
    sda_low = ~b;
    tick(3);
    scl = 1'b1;
    tick(3);
    s = sda;
    scl = 1'b0;
    tick(2);
  endtask
  task automatic step(input logic b);
    logic s;
    bit_io(b, s);
  endtask
  task automatic start();
    sda_low = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic stop();
    sda_low = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b0;
    tick(8);
  endtask
  task automatic send(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    report({7'h0, s});
  endtask
  task automatic recv(input logic nak);
    logic [7:0] v;
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      v[i] = s;
    end
    bit_io(nak, s);
    report(v);
  endtask
endmodule

//--- verif/quad_pot_two_wire_command_slave_test.sv
`timescale 1ns/100ps
module quad_pot_two_wire_command_slave_test
  import qpt_pkg::*;
;
  // device type for this bench; value is arbitrary
  localparam logic [3:0] DEV_T = 4'h6;
  logic clk = 1'b0;
  logic resetn, m_scl, m_low, m_tgl, sda_w, sda_oe_n, nv_write_busy;
  logic sda_out;
  logic [3:0] strap;
  logic [7:0] m_val;
  logic [POTS*TAPS-1:0] tap_switch_on;
  logic [POTS-1:0] chain_enable_flag, wiper_off_flag;
  logic [8:0] q [$];
  logic [7:0] sr [16];
  logic [7:0] wp [4];
  logic [31:0] seed;
  int err_count = 0;
  int n_tests = 0;
  always #50 clk = ~clk;
  // pulled-up data line: the slave's drive value only counts while enabled
  assign sda_w = ~(m_low | (~sda_oe_n & ~sda_out));
  qpt_core #(.WRITE_CYCLES(200), .DEVICE_TYPE(DEV_T)) dut (
    .clk(clk), .resetn(resetn), .scl(m_scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .address_select_inputs(strap),
    .tap_switch_on(tap_switch_on), .chain_enable_flag(chain_enable_flag),
    .wiper_off_flag(wiper_off_flag), .nv_write_busy(nv_write_busy));
  qpt_master m (.clk(clk), .sda(sda_w), .scl(m_scl), .sda_low(m_low),
    .res_tgl(m_tgl), .res_val(m_val));
  // ----------
  // checking
  // ----------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [63:0] e,
    input logic [63:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cmp_ack(input logic e, input logic g);
    check("ack", {63'h0, e}, {63'h0, g});
  endtask
  task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
    check("read byte", {56'h0, e}, {56'h0, g});
  endtask
  task automatic cmp_tap(input int g, input logic [7:0] b);
    check("taps", 64'h1 << b[5:0], tap_switch_on[g*TAPS +: TAPS]);
    check("flags", {62'h0, b[7:6]},
      {62'h0, chain_enable_flag[g], wiper_off_flag[g]});
  endtask
  // results come back in issue order, so the oldest note is the one due
  always @(m_tgl) begin
    logic [8:0] e;
    if ($time > 0) begin
      if (q.size() == 0) e = 9'h1FF;
      else e = q.pop_front();
      if (e[8]) cmp_byte(e[7:0], m_val);
      else cmp_ack(e[0], m_val[0]);
    end
  end
  // ----------
  // frames
  // ----------
  task automatic note(input logic k, input logic [7:0] v);
    q.push_back({k, v});
  endtask
  task automatic hail(input logic [7:0] a, input logic nak);
    m.start();
    note(1'b0, {7'h0, nak});
    m.send(a);
  endtask
  task automatic cmd(input logic [7:0] ins, input logic [7:0] d, int n);
    int k;
    hail({DEV_T, strap}, 1'b0);
    note(1'b0, 8'h00);
    m.send(ins);
    if (n == 3) begin
      note(1'b0, 8'h00);
      m.send(d);
    end
    m.stop();
    if (ins[7:4] inside {OP_WR_SSR, OP_WPR_TO_SSR, OP_ALL_WPR_TO_SSR}) begin
      hail({DEV_T, strap}, 1'b1);
      m.stop();
      for (k = 0; k < 1000 && nv_write_busy !== 1'b0; k++) m.tick(1);
    end
  endtask
  task automatic rd(input logic [7:0] ins, input logic [7:0] e);
    hail({DEV_T, strap}, 1'b0);
    note(1'b0, 8'h00);
    m.send(ins);
    note(1'b1, e);
    m.recv(1'b1);
    m.stop();
  endtask
  task automatic stepping(input logic [1:0] g, input logic [5:0] from,
    input logic [7:0] dirs, input logic [5:0] to);
    wp[g] = {wp[g][7:6], from};
    cmd({OP_WR_WPR, g, 2'h0}, wp[g], 3);
    hail({DEV_T, strap}, 1'b0);
    note(1'b0, 8'h00);
    m.send({OP_STEP, g, 2'h2});
    for (int i = 7; i >= 0; i--) m.step(dirs[i]);
    m.stop();
    wp[g][5:0] = to;
    rd({OP_RD_WPR, g, 2'h0}, wp[g]);
    cmp_tap(g, wp[g]);
  endtask
  task automatic reset_dut();
    resetn = 1'b0;
    m.tick(3);
    resetn = 1'b1;
    m.tick(30);
  endtask
  initial begin
    resetn = 1'b0;
    seed = lfsr(32'hEB62);
    strap = seed[3:0];
    reset_dut();
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      sr[i] = seed[7:0];
      cmd({OP_WR_SSR, i[3:0]}, sr[i], 3);
    end
    reset_dut();
    for (int g = 0; g < 4; g++) begin
      wp[g] = sr[g*4];
      cmp_tap(g, wp[g]);
    end
    for (int i = 0; i < 16; i++) rd({OP_RD_SSR, i[3:0]}, sr[i]);
    $display("test settings done");
    for (int g = 0; g < 4; g++) begin
      seed = lfsr(seed);
      wp[g] = seed[7:0];
      cmd({OP_WR_WPR, g[1:0], 2'h3}, wp[g], 3);
      cmp_tap(g, wp[g]);
      rd({OP_RD_WPR, g[1:0], 2'h1}, wp[g]);
    end
    $display("test wipers done");
    cmd({OP_SSR_TO_WPR, 4'hB}, 8'h00, 2);
    wp[2] = sr[11];
    cmp_tap(2, wp[2]);
    cmd({OP_WPR_TO_SSR, 4'h9}, 8'h00, 2);
    sr[9] = wp[2];
    rd({OP_RD_SSR, 4'h9}, sr[9]);
    cmd({OP_ALL_SSR_TO_WPR, 4'h6}, 8'h00, 2);
    for (int g = 0; g < 4; g++) begin
      wp[g] = sr[g*4+2];
      cmp_tap(g, wp[g]);
    end
    cmd({OP_ALL_WPR_TO_SSR, 4'hC}, 8'h00, 2);
    for (int g = 0; g < 4; g++) begin
      sr[g*4] = wp[g];
      rd({OP_RD_SSR, g[1:0], 2'h0}, sr[g*4]);
    end
    $display("test transfers done");
    stepping(2'h3, 6'h3B, 8'hFE, 6'h3D);
    stepping(2'h1, 6'h02, 8'h40, 6'h00);
    $display("test stepping done");
    hail({DEV_T, ~strap}, 1'b1);
    m.stop();
    hail({~DEV_T, strap}, 1'b1);
    m.stop();
    for (int o = 0; o < 16; o++) begin
      if (!(o inside {1, 2, 8, 9, 10, 11, 12, 13, 14})) begin
        hail({DEV_T, strap}, 1'b0);
        note(1'b0, 8'h01);
        m.send({o[3:0], 4'h0});
        m.stop();
      end
    end
    for (int g = 0; g < 4; g++) rd({OP_RD_WPR, g[1:0], 2'h0}, wp[g]);
    $display("test refusals done");
    if (q.size() != 0) err_count++;
    give_verdict();
  end
  initial begin
    #8000000;
    err_count++;
    give_verdict();
  end
endmodule
